/* File: design/amtps_map.vh */
`ifndef AMTPS_MAP_VH
`define AMTPS_MAP_VH

// Register byte offsets
`define AMTPS_OFS_TRIG3_SEL 8'h00
`define AMTPS_OFS_TRIG4_SEL 8'h04
`define AMTPS_OFS_TRIG5_SEL 8'h08
`define AMTPS_OFS_PROG0_IRQ 8'h0c
`define AMTPS_OFS_PROG1_IRQ 8'h10
`define AMTPS_OFS_PROG2_IRQ 8'h14
`define AMTPS_OFS_STATUS 8'h18
`define AMTPS_OFS_MASK 8'h1c
`define AMTPS_OFS_RESULT0 8'h20
`define AMTPS_OFS_RESULT1 8'h24
`define AMTPS_OFS_RESULT2 8'h28
`define AMTPS_OFS_RESULT3 8'h2c

// Trigger selector fields
`define AMTPS_SEL_EN_BIT 7
`define AMTPS_SEL_PROG_MSB 2
`define AMTPS_SEL_PROG_LSB 0
`define AMTPS_PROG_LAST 3'h5

// Interrupt select field and codes
`define AMTPS_IRQ_MSB 1
`define AMTPS_IRQ_LSB 0
`define AMTPS_IRQ_NONE 2'h0
`define AMTPS_IRQ_RSVD 2'h1
`define AMTPS_IRQ_DONE 2'h2
`define AMTPS_IRQ_NONE2 2'h3

// Status and mask bits
`define AMTPS_ST_DONE 0
`define AMTPS_ST_DISABLED 1
`define AMTPS_ST_RESERVED 2
`define AMTPS_ST_OVERRUN 3
`define AMTPS_ST_WIDTH 4

// Reset values
`define AMTPS_RST_SEL 8'h00
`define AMTPS_RST_IRQ 2'h0
`define AMTPS_RST_STATUS 4'h0
`define AMTPS_RST_MASK 4'h0
`define AMTPS_RST_RESULT 12'h000

`endif

/* File: design/amtps_trig.v */
`timescale 1ns/1ns
`default_nettype none
`include "amtps_map.vh"

// One motor-driver trigger: selector register, gating and a pending start.
module amtps_trig (
  input wire clock,
  input wire srst,
  input wire wr_en,
  input wire [7:0] wr_data,
  input wire trig,
  input wire grant,
  output wire [7:0] sel_value,
  output reg pending,
  output reg [2:0] pend_program,
  output reg hit_disabled,
  output reg hit_reserved,
  output reg hit_overrun
);

  reg enable;
  reg [2:0] program_number;
  wire code_ok;
  wire accept;

  assign sel_value = {enable, 4'h0, program_number};
  assign code_ok = (program_number <= `AMTPS_PROG_LAST);
  assign accept = trig & enable & code_ok;

  always @(posedge clock) begin
    if (srst) begin
      enable <= 1'b0;
      program_number <= 3'h0;
      pending <= 1'b0;
      pend_program <= 3'h0;
      hit_disabled <= 1'b0;
      hit_reserved <= 1'b0;
      hit_overrun <= 1'b0;
    end else begin
      if (wr_en) begin
        enable <= wr_data[`AMTPS_SEL_EN_BIT];
        program_number <= wr_data[`AMTPS_SEL_PROG_MSB:`AMTPS_SEL_PROG_LSB];
      end
      // A new trigger beats the grant; one landing on an ungranted pending start overwrites it and sets overrun
      if (accept) begin
        pending <= 1'b1;
        pend_program <= program_number;
      end else if (grant) begin
        pending <= 1'b0;
      end
      hit_disabled <= trig & ~enable;
      // Reserved codes never start a program
      hit_reserved <= trig & enable & ~code_ok;
      hit_overrun <= accept & pending & ~grant;
    end
  end

endmodule

`default_nettype wire

/* File: design/amtps_top.v */
`timescale 1ns/1ns
`default_nettype none
`include "amtps_map.vh"

//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Trigger 3 enable at bit 7
// - Trigger 4 enable at bit 7
// - Trigger 5 enable at bit 7
// - Program number bits 2-0, codes 6-7 reserved
// - Interrupt code 10 raises done interrupt
// - Program 0 uses interrupt selector 0
// - Program 1 uses interrupt selector 1
// - Three triggers, each own selector, in order
// - Slot m result goes to register m
module amtps_top #(
  parameter RESULT_WIDTH = 12
) (
  input wire clock,
  input wire srst,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [31:0] reg_rdata,
  input wire motor_trigger_3,
  input wire motor_trigger_4,
  input wire motor_trigger_5,
  input wire start_ready,
  output reg start_valid,
  output reg [2:0] start_program,
  output reg [2:0] start_trigger,
  input wire program_done,
  input wire [2:0] done_program,
  input wire slot_valid,
  input wire [1:0] slot_index,
  input wire [RESULT_WIDTH-1:0] slot_result,
  output reg motor_trigger_done_irq,
  output reg irq
);

  //////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function [7:0] trig_offset;
    input integer k;
    begin
      case (k)
        0: trig_offset = `AMTPS_OFS_TRIG3_SEL;
        1: trig_offset = `AMTPS_OFS_TRIG4_SEL;
        default: trig_offset = `AMTPS_OFS_TRIG5_SEL;
      endcase
    end
  endfunction

  function [7:0] irq_offset;
    input integer k;
    begin
      case (k)
        0: irq_offset = `AMTPS_OFS_PROG0_IRQ;
        1: irq_offset = `AMTPS_OFS_PROG1_IRQ;
        default: irq_offset = `AMTPS_OFS_PROG2_IRQ;
      endcase
    end
  endfunction

  function [7:0] result_offset;
    input integer k;
    begin
      case (k)
        0: result_offset = `AMTPS_OFS_RESULT0;
        1: result_offset = `AMTPS_OFS_RESULT1;
        2: result_offset = `AMTPS_OFS_RESULT2;
        default: result_offset = `AMTPS_OFS_RESULT3;
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Address decode for the write path; the read path decodes reg_addr itself

  wire [2:0] sel_hit;
  wire [2:0] prog_irq_hit;
  wire status_hit;
  wire mask_hit;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : reg_decode
      // Each trigger has its own selector in ascending order
      assign sel_hit[g] = (reg_addr == trig_offset(g));
      assign prog_irq_hit[g] = (reg_addr == irq_offset(g));
    end
  endgenerate

  assign status_hit = (reg_addr == `AMTPS_OFS_STATUS);
  assign mask_hit = (reg_addr == `AMTPS_OFS_MASK);

  //////////////////////////////////////////////////////////////////////////////
  // Trigger selectors 3 to 5

  wire [2:0] trig_in;
  wire [2:0] trig_wr;
  wire [2:0] grant;
  wire [2:0] pend;
  wire [2:0] hit_disabled;
  wire [2:0] hit_reserved;
  wire [2:0] hit_overrun;
  wire [23:0] sel_bus;
  wire [8:0] pend_prog_bus;

  assign trig_in = {motor_trigger_5, motor_trigger_4, motor_trigger_3};

  generate
    for (g = 0; g < 3; g = g + 1) begin : trig_slot
      assign trig_wr[g] = reg_write & sel_hit[g];
      amtps_trig u_trig (
        .clock(clock),
        .srst(srst),
        .wr_en(trig_wr[g]),
        .wr_data(reg_wdata[7:0]),
        .trig(trig_in[g]),
        .grant(grant[g]),
        .sel_value(sel_bus[8*g+7:8*g]),
        .pending(pend[g]),
        .pend_program(pend_prog_bus[3*g+2:3*g]),
        .hit_disabled(hit_disabled[g]),
        .hit_reserved(hit_reserved[g]),
        .hit_overrun(hit_overrun[g])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Start arbitration: lowest trigger number first, one start per cycle

  assign grant[0] = start_ready & pend[0];
  assign grant[1] = start_ready & pend[1] & ~pend[0];
  assign grant[2] = start_ready & pend[2] & ~pend[1] & ~pend[0];

  reg [2:0] next_start_program;
  reg [2:0] next_start_trigger;

  always @* begin
    next_start_program = 3'h0;
    next_start_trigger = 3'h0;
    if (grant[0]) begin
      next_start_program = pend_prog_bus[2:0];
      next_start_trigger = 3'h3;
    end else if (grant[1]) begin
      next_start_program = pend_prog_bus[5:3];
      next_start_trigger = 3'h4;
    end else if (grant[2]) begin
      next_start_program = pend_prog_bus[8:6];
      next_start_trigger = 3'h5;
    end
  end

  always @(posedge clock) begin
    if (srst) begin
      start_valid <= 1'b0;
      start_program <= 3'h0;
      start_trigger <= 3'h0;
    end else begin
      start_valid <= |grant;
      if (|grant) begin
        start_program <= next_start_program;
        start_trigger <= next_start_trigger;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Completion interrupt selectors for programs 0 to 2

  reg [1:0] irq_code [0:2];
  reg [1:0] done_code;
  integer i;
  integer j;

  always @(posedge clock) begin
    if (srst) begin
      for (i = 0; i < 3; i = i + 1) begin
        irq_code[i] <= `AMTPS_RST_IRQ;
      end
    end else if (reg_write) begin
      for (i = 0; i < 3; i = i + 1) begin
        if (prog_irq_hit[i]) begin
          irq_code[i] <= reg_wdata[`AMTPS_IRQ_MSB:`AMTPS_IRQ_LSB];
        end
      end
    end
  end

  // Programs 3 to 5 carry no selector here and so never interrupt
  always @* begin
    case (done_program)
      3'h0: done_code = irq_code[0];
      3'h1: done_code = irq_code[1];
      3'h2: done_code = irq_code[2];
      default: done_code = `AMTPS_IRQ_NONE;
    endcase
  end

  wire done_event;
  // Codes 00, 01 and 11 stay silent
  assign done_event = program_done & (done_code == `AMTPS_IRQ_DONE);

  always @(posedge clock) begin
    if (srst) begin
      motor_trigger_done_irq <= 1'b0;
    end else begin
      motor_trigger_done_irq <= done_event;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Conversion results, one register per slot

  reg [RESULT_WIDTH-1:0] result [0:3];

  always @(posedge clock) begin
    if (srst) begin
      for (j = 0; j < 4; j = j + 1) begin
        result[j] <= `AMTPS_RST_RESULT;
      end
    end else if (slot_valid) begin
      result[slot_index] <= slot_result;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sticky status, mask and interrupt line

  reg [`AMTPS_ST_WIDTH-1:0] status;
  reg [`AMTPS_ST_WIDTH-1:0] mask;
  wire [`AMTPS_ST_WIDTH-1:0] st_set;
  wire [`AMTPS_ST_WIDTH-1:0] st_clr;
  wire [`AMTPS_ST_WIDTH-1:0] next_status;
  wire [`AMTPS_ST_WIDTH-1:0] next_mask;

  assign st_set[`AMTPS_ST_DONE] = done_event;
  assign st_set[`AMTPS_ST_DISABLED] = |hit_disabled;
  assign st_set[`AMTPS_ST_RESERVED] = |hit_reserved;
  assign st_set[`AMTPS_ST_OVERRUN] = |hit_overrun;
  assign st_clr = (reg_write && status_hit) ?
                  reg_wdata[`AMTPS_ST_WIDTH-1:0] : {`AMTPS_ST_WIDTH{1'b0}};
  // Set beats write-one-to-clear in the same cycle
  assign next_status = (status & ~st_clr) | st_set;
  assign next_mask = (reg_write && mask_hit) ?
                     reg_wdata[`AMTPS_ST_WIDTH-1:0] : mask;

  always @(posedge clock) begin
    if (srst) begin
      status <= `AMTPS_RST_STATUS;
      mask <= `AMTPS_RST_MASK;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      mask <= next_mask;
      // Registered from the next state so irq follows status and mask
      // with no lag
      irq <= |(next_status & next_mask);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read port: data one cycle after the strobe, zero otherwise

  reg [31:0] next_rdata;

  always @* begin
    next_rdata = 32'h0000_0000;
    case (reg_addr)
      `AMTPS_OFS_TRIG3_SEL: next_rdata = {24'h000000, sel_bus[7:0]};
      `AMTPS_OFS_TRIG4_SEL: next_rdata = {24'h000000, sel_bus[15:8]};
      `AMTPS_OFS_TRIG5_SEL: next_rdata = {24'h000000, sel_bus[23:16]};
      `AMTPS_OFS_PROG0_IRQ: next_rdata = {30'h0, irq_code[0]};
      `AMTPS_OFS_PROG1_IRQ: next_rdata = {30'h0, irq_code[1]};
      `AMTPS_OFS_PROG2_IRQ: next_rdata = {30'h0, irq_code[2]};
      `AMTPS_OFS_STATUS: next_rdata = {28'h0000000, status};
      `AMTPS_OFS_MASK: next_rdata = {28'h0000000, mask};
      result_offset(0): next_rdata[RESULT_WIDTH-1:0] = result[0];
      result_offset(1): next_rdata[RESULT_WIDTH-1:0] = result[1];
      result_offset(2): next_rdata[RESULT_WIDTH-1:0] = result[2];
      result_offset(3): next_rdata[RESULT_WIDTH-1:0] = result[3];
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge clock) begin
    if (srst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule

`default_nettype wire

/* File: dv/amtps_engine.sv */
`timescale 1ns/1ns
`default_nettype none
// Conversion engine stand-in: takes one start, reports it done later
module amtps_engine (
  input wire logic clock,
  input wire logic srst,
  input wire logic slow,
  input wire logic start_valid,
  input wire logic [2:0] start_program,
  output logic start_ready,
  output logic program_done,
  output logic [2:0] done_program
);
  logic [3:0] left;
  logic [2:0] prog;
  // Ready drops in the start cycle so no second start slips in behind
  assign start_ready = (left == 4'h0) && !start_valid;
  // Number only means something beside the done pulse
  assign done_program = program_done ? prog : ~prog;
  always @(posedge clock) begin
    program_done <= 1'b0;
    if (srst) begin
      left <= 4'h0;
      prog <= 3'h0;
    end else if (start_valid) begin
      left <= slow ? 4'h9 : 4'h2;
      prog <= start_program;
    end else if (left != 4'h0) begin
      left <= left - 4'h1;
      program_done <= (left == 4'h1);
    end
  end
endmodule
`default_nettype wire

/* File: dv/amtps_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module amtps_checker (
  input wire logic clock,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_read,
  input wire logic reg_write,
  input wire logic [31:0] reg_rdata,
  input wire logic start_ready,
  input wire logic start_valid,
  input wire logic [2:0] start_program,
  input wire logic [2:0] start_trigger,
  input wire logic program_done,
  input wire logic [2:0] done_program,
  input wire logic motor_trigger_done_irq,
  input wire logic irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  sequence s_sel_rd; reg_read && reg_addr inside {8'h00, 8'h04, 8'h08};
  endsequence
  sequence s_irq_rd; reg_read && reg_addr inside {8'h0c, 8'h10}; endsequence
  property p_sel_rd; s_sel_rd |=> (reg_rdata & 32'hffffff78) == 32'h0;
  endproperty
  property p_irq_rd; s_irq_rd |=> (reg_rdata & 32'hfffffffc) == 32'h0;
  endproperty
  property p_rd_idle; !reg_read |=> reg_rdata == 32'h0; endproperty
  property p_start_one; start_valid |=> !start_valid; endproperty
  property p_start_rdy; start_valid |-> $past(start_ready); endproperty
  property p_start_rng;
    start_valid |-> start_program <= 3'h5 && start_trigger inside {3, 4, 5};
  endproperty
  property p_done_src;
    motor_trigger_done_irq |-> $past(program_done) && $past(done_program) < 3;
  endproperty
  property p_irq_hold; irq && !reg_write |=> irq; endproperty
  property p_rst_quiet; disable iff (1'b0)
    srst |=> !start_valid && !irq && !motor_trigger_done_irq;
  endproperty
  a_sel_rd: assert property (p_sel_rd) else $error("sel stray bits");
  a_irq_rd: assert property (p_irq_rd) else $error("irq stray bits");
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not 0");
  a_start_one: assert property (p_start_one) else $error("long start");
  a_start_rdy: assert property (p_start_rdy) else $error("not ready");
  a_start_rng: assert property (p_start_rng) else $error("bad start");
  a_done_src: assert property (p_done_src) else $error("stray done");
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
  a_rst_quiet: assert property (p_rst_quiet) else $error("reset");
endmodule
bind amtps_top amtps_checker amtps_checker_i (.clock(clock), .srst(srst),
  .reg_addr(reg_addr), .reg_read(reg_read), .reg_write(reg_write),
  .reg_rdata(reg_rdata), .start_ready(start_ready),
  .start_valid(start_valid), .start_program(start_program),
  .start_trigger(start_trigger), .program_done(program_done),
  .done_program(done_program), .irq(irq),
  .motor_trigger_done_irq(motor_trigger_done_irq));
`default_nettype wire

/* File: dv/amtps_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module amtps_bench;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata, d;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic slot_valid = 1'b0;
  logic slow = 1'b0;
  logic [2:0] mt = 3'h0;
  logic [1:0] slot_index = 2'h0;
  logic [11:0] slot_result = 12'h0;
  logic start_ready, start_valid, program_done, motor_trigger_done_irq, irq;
  logic [2:0] start_program, start_trigger, done_program;
  integer errors = 0, samples_checked = 0, seed = 33801, cycles = 0;
  integer n_st = 0, n_irq = 0, k, p, c, n0;
  logic [8:0] st_log = 9'h0;
  amtps_top amtps_top_i (.clock(clock), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .motor_trigger_3(mt[0]),
    .motor_trigger_4(mt[1]), .motor_trigger_5(mt[2]),
    .start_ready(start_ready), .start_valid(start_valid),
    .start_program(start_program), .start_trigger(start_trigger),
    .program_done(program_done), .done_program(done_program),
    .slot_valid(slot_valid), .slot_index(slot_index),
    .slot_result(slot_result), .irq(irq),
    .motor_trigger_done_irq(motor_trigger_done_irq));
  amtps_engine amtps_engine_i (.clock(clock), .srst(srst), .slow(slow),
    .start_valid(start_valid), .start_program(start_program),
    .start_ready(start_ready), .program_done(program_done),
    .done_program(done_program));
  always #25 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    n_st <= n_st + start_valid;
    n_irq <= n_irq + motor_trigger_done_irq;
    if (start_valid) st_log <= {st_log[5:0], start_trigger};
    if (cycles == 20000) begin
      errors = errors + 1;
      end_of_test;
    end
  end
  task end_of_test;
    if (errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string s);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("[ERR] %s expected %h seen %h", s, exp, seen);
    end
  endtask
  // Selector read-back keeps only the enable bit and the program field
  function automatic logic [31:0] sel_exp(input logic [31:0] v);
    return v & 32'h0000_0087;
  endfunction
  // Only interrupt code 10 raises the completion interrupt
  function automatic logic [31:0] done_exp(input integer code);
    return (code == 2) ? 32'h1 : 32'h0;
  endfunction
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp, input string s);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    chk(reg_rdata, exp, s);
  endtask
  // Fires one trigger and waits long enough for a slow engine to finish
  task fire(input integer t);
    @(posedge clock);
    slow <= $random(seed);
    mt <= 3'h1 << (t - 3);
    @(posedge clock);
    mt <= 3'h0;
    repeat (16) @(posedge clock);
    @(negedge clock);
  endtask
  initial begin
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    for (k = 0; k < 6; k++) rd(8'h04 * k, 32'h0, "reset");
    rd(8'h40, 32'h0, "unmapped");
    for (k = 0; k < 3; k++) begin
      d = $random(seed);
      wr(8'h04 * k, d);
      rd(8'h04 * k, sel_exp(d), "sel");
    end
    for (k = 3; k < 9; k++) begin
      p = {$random(seed)} % 6;
      wr(8'h04 * (k % 3), 32'h80 | p);
      n0 = n_st;
      fire(k % 3 + 3);
      chk(n_st - n0, 1, "starts");
      chk(start_trigger, k % 3 + 3, "trigger");
      chk(start_program, p, "program");
    end
    // Disabled, then enabled with a reserved code: no start, status flags
    for (k = 0; k < 2; k++) begin
      wr(8'h18, 32'hf);
      wr(8'h04, k ? 32'h86 : 32'h05);
      n0 = n_st;
      fire(4);
      chk(n_st - n0, 0, "refused");
      rd(8'h18, k ? 32'h4 : 32'h2, "status");
    end
    wr(8'h18, 32'hf);
    wr(8'h1c, 32'h1);
    for (k = 0; k < 9; k++) begin
      p = k % 2;
      c = k < 8 ? k / 2 : 2;
      if (k == 8) wr(8'h1c, 32'h0);
      wr(8'h0c + 8'h04 * p, 32'hfffffffc | c);
      rd(8'h0c + 8'h04 * p, c, "irq sel");
      wr(8'h08, 32'h80 | p);
      n0 = n_irq;
      fire(5);
      chk(n_irq - n0, done_exp(c), "done irq");
      chk(irq, c == 2 && k < 8, "irq level");
      rd(8'h18, done_exp(c), "done flag");
      wr(8'h18, 32'h1);
      rd(8'h18, 32'h0, "cleared");
      chk(irq, 0, "irq clear");
    end
    for (k = 0; k < 4; k++) begin
      d = $random(seed);
      @(posedge clock);
      slot_valid <= 1'b1;
      slot_index <= k;
      slot_result <= d[11:0];
      @(posedge clock);
      slot_valid <= 1'b0;
      rd(8'h20 + 8'h04 * k, d & 32'hfff, "result");
    end
    // All three triggers at once, trigger 5 again while still pending
    wr(8'h14, 32'h2);
    wr(8'h00, 32'h82);
    wr(8'h04, 32'h84);
    wr(8'h08, 32'h85);
    n0 = n_st;
    c = n_irq;
    @(posedge clock);
    mt <= 3'h7;
    @(posedge clock);
    mt <= 3'h4;
    @(posedge clock);
    mt <= 3'h0;
    repeat (40) @(posedge clock);
    @(negedge clock);
    chk(n_st - n0, 3, "burst starts");
    chk(st_log, 9'he5, "start order");
    chk(start_program, 5, "last program");
    chk(n_irq - c, 1, "program 2 irq");
    rd(8'h18, 32'h9, "overrun");
    // Reset in mid-run must bring every register back to zero
    @(posedge clock);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    for (k = 0; k < 12; k++) rd(8'h04 * k, 32'h0, "rerun");
    end_of_test;
  end
endmodule
`default_nettype wire
